/* src/hmbx_pkg.sv */
package hmbx_pkg;

	localparam int unsigned WB_AW       = 8;
	localparam int unsigned WB_DW       = 32;
	localparam int unsigned WB_SW       = 4;
	localparam int unsigned CHIP_LINES  = 4;
	localparam int unsigned IRQ_BITS    = 6;

	// Register byte offsets on the processor bus.
	localparam logic [WB_AW-1:0] OFS_INBOUND   = 8'h00;
	localparam logic [WB_AW-1:0] OFS_OUTBOUND  = 8'h04;
	localparam logic [WB_AW-1:0] OFS_STATUS    = 8'h08;
	localparam logic [WB_AW-1:0] OFS_EVENT     = 8'h0C;
	localparam logic [WB_AW-1:0] OFS_EVENT_SET = 8'h10;
	localparam logic [WB_AW-1:0] OFS_EVENT_CLR = 8'h14;
	localparam logic [WB_AW-1:0] OFS_IRQ_STAT  = 8'h18;
	localparam logic [WB_AW-1:0] OFS_IRQ_MASK  = 8'h1C;

	// Field positions.
	localparam int unsigned STAT_INB_FULL   = 0;
	localparam int unsigned STAT_OUTB_READY = 1;
	localparam int unsigned EVT_IN_LSB      = 0;
	localparam int unsigned EVT_OUT_LSB     = 4;
	localparam int unsigned IRQ_HOST_WR     = 0;
	localparam int unsigned IRQ_HOST_RD     = 1;
	localparam int unsigned IRQ_IN_LSB      = 2;

	// Reset values.
	localparam logic [CHIP_LINES-1:0] EVT_OUT_RST  = 4'h0;
	localparam logic [IRQ_BITS-1:0]   IRQ_MASK_RST = 6'h00;

	typedef enum logic [1:0] {
		HMBX_WB_IDLE = 2'b01,
		HMBX_WB_ACK  = 2'b10
	} hmbx_wb_state_t;

endpackage : hmbx_pkg

/* src/hmbx_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module hmbx_sync #(
	parameter int unsigned W = 4
) (
	input  wire logic         clk_i,  // Device clock.
	input  wire logic         rst_i,  // Synchronous reset, active high.
	input  wire logic [W-1:0] d_i,    // Asynchronous levels.
	output logic      [W-1:0] q_o     // Levels in the clock domain.
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} hmbx_sync_t;

	hmbx_sync_t s_r;
	hmbx_sync_t s_nxt;

	// The first stage feeds only the second stage.
	always_comb begin
		s_nxt.meta   = d_i;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q_o = s_r.stable;
endmodule : hmbx_sync
`default_nettype wire

/* src/hmbx_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module hmbx_flag (
	input  wire logic clk_i,  // Device clock.
	input  wire logic rst_i,  // Synchronous reset, active high.
	input  wire logic set_i,  // One-cycle set pulse.
	input  wire logic clr_i,  // One-cycle clear pulse.
	output logic      flag_o  // Registered flag.
);
	typedef struct packed {
		logic flag;
	} hmbx_flag_t;

	hmbx_flag_t s_r;
	hmbx_flag_t s_nxt;

	// A set in the same cycle as a clear wins, so a fresh message is never lost.
	always_comb begin
		s_nxt = s_r;
		if (set_i) begin
			s_nxt.flag = 1'b1;
		end else if (clr_i) begin
			s_nxt.flag = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign flag_o = s_r.flag;
endmodule : hmbx_flag
`default_nettype wire

/* src/hmbx_top.sv */
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module hmbx_top
	import hmbx_pkg::*;
#(
	parameter int unsigned                     HOST_DW  = 32,
	parameter logic [hmbx_pkg::CHIP_LINES-1:0] OUT_INIT = hmbx_pkg::EVT_OUT_RST
) (
	input  wire logic                       clk_i,                   // Device clock.
	input  wire logic                       rst_i,                   // Synchronous reset, high.
	input  wire logic                       wb_cyc_i,                // Bus cycle.
	input  wire logic                       wb_stb_i,                // Bus strobe.
	input  wire logic                       wb_we_i,                 // Write enable.
	input  wire logic [hmbx_pkg::WB_AW-1:0] wb_adr_i,                // Byte address.
	input  wire logic [hmbx_pkg::WB_DW-1:0] wb_dat_i,                // Write data.
	input  wire logic [hmbx_pkg::WB_SW-1:0] wb_sel_i,                // Byte selects.
	output logic      [hmbx_pkg::WB_DW-1:0] wb_dat_o,                // Read data.
	output logic                            wb_ack_o,                // Acknowledge.
	output logic                            irq_o,                   // Level interrupt.
	input  wire logic                       mailbox_select_i,        // Host mailbox select.
	input  wire logic                       host_read_not_write_i,   // Host 1 read, 0 write.
	input  wire logic [HOST_DW-1:0]         host_wdata_i,            // Host write data.
	output logic      [HOST_DW-1:0]         host_rdata_o,            // Host read data.
	output logic                            inbound_full_o,          // Inbound holds unread data.
	output logic                            outbound_ready_o,        // Outbound holds a response.
	input  wire logic                       chip_event_in_a_i,       // Event input A.
	input  wire logic                       chip_event_in_b_i,       // Event input B.
	input  wire logic                       chip_event_in_c_i,       // Event input C.
	input  wire logic                       chip_event_in_d_i,       // Event input D.
	output logic                            chip_state_out_a_o,      // State output A.
	output logic                            chip_state_out_b_o,      // State output B.
	output logic                            chip_state_out_c_o,      // State output C.
	output logic                            chip_state_out_d_o       // State output D.
);
	import hmbx_pkg::*;

	typedef struct packed {
		hmbx_wb_state_t          wb_state;
		logic [WB_DW-1:0]        wb_rdata;
		logic [HOST_DW-1:0]      inbound;
		logic [HOST_DW-1:0]      outbound;
		logic [HOST_DW-1:0]      host_rdata;
		logic                    sel_prev;
		logic [CHIP_LINES-1:0]   evt_out;
		logic [CHIP_LINES-1:0]   in_prev;
		logic [IRQ_BITS-1:0]     irq_stat;
		logic [IRQ_BITS-1:0]     irq_mask;
		logic                    irq;
	} hmbx_state_t;

	hmbx_state_t s_r;
	hmbx_state_t s_nxt;

	logic [CHIP_LINES-1:0] in_raw;
	logic [CHIP_LINES-1:0] in_sync;
	logic [CHIP_LINES-1:0] in_rise;
	logic                  inb_full;
	logic                  outb_ready;
	logic                  wb_take;
	logic                  wb_wr;
	logic                  wb_rd;
	logic                  host_take;
	logic                  host_wr;
	logic                  host_rd;
	logic                  rd_inbound;
	logic                  wr_outbound;

	// Merges write data into a register under the byte selects.
	function automatic logic [WB_DW-1:0] merge(
		input logic [WB_DW-1:0] old_v,
		input logic [WB_DW-1:0] new_v,
		input logic [WB_SW-1:0] sel
	);
		logic [WB_DW-1:0] res;
		res = old_v;
		for (int i = 0; i < WB_SW; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	assign in_raw = {chip_event_in_d_i, chip_event_in_c_i, chip_event_in_b_i, chip_event_in_a_i};

	hmbx_sync #(
		.W(CHIP_LINES)
	) u_in_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i  (in_raw),
		.q_o  (in_sync)
	);

	// Edges are taken from the synchronised copy only.
	assign in_rise = in_sync & ~s_r.in_prev;

	assign wb_take     = wb_cyc_i & wb_stb_i & (s_r.wb_state == HMBX_WB_IDLE);
	assign wb_wr       = wb_take & wb_we_i;
	assign wb_rd       = wb_take & ~wb_we_i;
	assign rd_inbound  = wb_rd & (wb_adr_i == OFS_INBOUND);
	assign wr_outbound = wb_wr & (wb_adr_i == OFS_OUTBOUND);

	// One host access per rising edge of the select, so a held select is not a burst.
	assign host_take = mailbox_select_i & ~s_r.sel_prev;
	assign host_wr   = host_take & ~host_read_not_write_i;
	assign host_rd   = host_take & host_read_not_write_i;

	hmbx_flag u_inb_full (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.set_i (host_wr),
		.clr_i (rd_inbound),
		.flag_o(inb_full)
	);

	hmbx_flag u_outb_ready (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.set_i (wr_outbound),
		.clr_i (host_rd),
		.flag_o(outb_ready)
	);

	always_comb begin
		logic [IRQ_BITS-1:0] ev;
		logic [IRQ_BITS-1:0] w1c;
		logic [WB_DW-1:0]    wv;
		ev  = '0;
		w1c = '0;
		wv  = '0;
		s_nxt = s_r;
		s_nxt.sel_prev = mailbox_select_i;
		s_nxt.in_prev  = in_sync;

		case (s_r.wb_state)
			HMBX_WB_IDLE: begin
				if (wb_take) begin
					s_nxt.wb_state = HMBX_WB_ACK;
				end
			end
			HMBX_WB_ACK: begin
				s_nxt.wb_state = HMBX_WB_IDLE;
			end
			default: begin
				s_nxt.wb_state = HMBX_WB_IDLE;
			end
		endcase

		if (host_wr) begin
			s_nxt.inbound = host_wdata_i;
		end
		if (host_rd) begin
			s_nxt.host_rdata = s_r.outbound;
		end

		// Read data is captured at the accepting edge and shown with the acknowledge.
		if (wb_rd) begin
			if (wb_adr_i == OFS_INBOUND) begin
				s_nxt.wb_rdata = WB_DW'(s_r.inbound);
			end else if (wb_adr_i == OFS_OUTBOUND) begin
				s_nxt.wb_rdata = WB_DW'(s_r.outbound);
			end else if (wb_adr_i == OFS_STATUS) begin
				s_nxt.wb_rdata = '0;
				s_nxt.wb_rdata[STAT_INB_FULL]   = inb_full;
				s_nxt.wb_rdata[STAT_OUTB_READY] = outb_ready;
			end else if (wb_adr_i == OFS_EVENT) begin
				s_nxt.wb_rdata = '0;
				s_nxt.wb_rdata[EVT_IN_LSB +: CHIP_LINES]  = in_sync;
				s_nxt.wb_rdata[EVT_OUT_LSB +: CHIP_LINES] = s_r.evt_out;
			end else if (wb_adr_i == OFS_IRQ_STAT) begin
				s_nxt.wb_rdata = WB_DW'(s_r.irq_stat);
			end else if (wb_adr_i == OFS_IRQ_MASK) begin
				s_nxt.wb_rdata = WB_DW'(s_r.irq_mask);
			end else begin
				s_nxt.wb_rdata = '0;
			end
		end

		if (wb_wr) begin
			if (wb_adr_i == OFS_OUTBOUND) begin
				wv = merge(WB_DW'(s_r.outbound), wb_dat_i, wb_sel_i);
				s_nxt.outbound = wv[HOST_DW-1:0];
			end else if (wb_adr_i == OFS_EVENT) begin
				wv = merge('0, wb_dat_i, wb_sel_i);
				if (wb_sel_i[0]) begin
					s_nxt.evt_out = wv[EVT_OUT_LSB +: CHIP_LINES];
				end
			end else if (wb_adr_i == OFS_EVENT_SET) begin
				wv = merge('0, wb_dat_i, wb_sel_i);
				s_nxt.evt_out = s_r.evt_out | wv[CHIP_LINES-1:0];
			end else if (wb_adr_i == OFS_EVENT_CLR) begin
				wv = merge('0, wb_dat_i, wb_sel_i);
				s_nxt.evt_out = s_r.evt_out & ~wv[CHIP_LINES-1:0];
			end else if (wb_adr_i == OFS_IRQ_STAT) begin
				wv  = merge('0, wb_dat_i, wb_sel_i);
				w1c = wv[IRQ_BITS-1:0];
			end else if (wb_adr_i == OFS_IRQ_MASK) begin
				wv = merge(WB_DW'(s_r.irq_mask), wb_dat_i, wb_sel_i);
				s_nxt.irq_mask = wv[IRQ_BITS-1:0];
			end
		end

		// A fresh event beats a write-one-to-clear in the same cycle.
		ev[IRQ_HOST_WR] = host_wr;
		ev[IRQ_HOST_RD] = host_rd;
		ev[IRQ_IN_LSB +: CHIP_LINES] = in_rise;
		s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | ev;
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r          <= '0;
			s_r.wb_state <= HMBX_WB_IDLE;
			// The state lines leave reset at a known level for board start-up.
			s_r.evt_out  <= OUT_INIT;
			s_r.irq_mask <= IRQ_MASK_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_ack_o           = (s_r.wb_state == HMBX_WB_ACK);
	assign wb_dat_o           = s_r.wb_rdata;
	assign irq_o              = s_r.irq;
	assign host_rdata_o       = s_r.host_rdata;
	assign inbound_full_o     = inb_full;
	assign outbound_ready_o   = outb_ready;
	assign chip_state_out_a_o = s_r.evt_out[0];
	assign chip_state_out_b_o = s_r.evt_out[1];
	assign chip_state_out_c_o = s_r.evt_out[2];
	assign chip_state_out_d_o = s_r.evt_out[3];

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_host_write;
		mailbox_select_i && !s_r.sel_prev && !host_read_not_write_i;
	endsequence

	sequence s_host_read;
		mailbox_select_i && !s_r.sel_prev && host_read_not_write_i;
	endsequence

	sequence s_poll_read;
		wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == OFS_EVENT && !wb_ack_o;
	endsequence

	a_inb_full_set: assert property (s_host_write |=> inbound_full_o)
		else $error("inbound_full not set after host write");

	a_inb_full_clr: assert property (rd_inbound && !host_wr |=> !inbound_full_o)
		else $error("inbound_full not cleared after processor read");

	a_outb_rdy_set: assert property (wr_outbound |=> outbound_ready_o [*2] or
			(outbound_ready_o ##1 $past(host_rd)))
		else $error("outbound_ready not set after processor write");

	a_outb_rdy_clr: assert property (s_host_read and !wr_outbound |=> !outbound_ready_o)
		else $error("outbound_ready not cleared after host read");

	a_host_wr_data: assert property (s_host_write |=> s_r.inbound == $past(host_wdata_i))
		else $error("inbound register missed host data");

	a_host_rd_data: assert property (s_host_read |=> host_rdata_o == $past(s_r.outbound))
		else $error("host read data not from outbound register");

	a_poll_lines: assert property (s_poll_read |=> wb_ack_o
			&& wb_dat_o[EVT_IN_LSB +: CHIP_LINES] == $past(in_sync))
		else $error("polled lines do not match synchronised inputs");

	a_evt_sticky: assert property (|in_rise |=> (s_r.irq_stat[IRQ_IN_LSB +: CHIP_LINES]
			& $past(in_rise)) == $past(in_rise))
		else $error("input edge not captured as event");

	a_out_follow: assert property (wb_wr && wb_adr_i == OFS_EVENT_SET && wb_sel_i[0]
			|=> (s_r.evt_out & $past(wb_dat_i[CHIP_LINES-1:0]))
			== $past(wb_dat_i[CHIP_LINES-1:0]))
		else $error("state output not set by event set write");

	a_ack_single: assert property (wb_take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus acknowledge not a single cycle");
endmodule : hmbx_top
`default_nettype wire

/* dv/hmbx_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hmbx_host_model (
	input  wire logic        clk_i,    // Device clock.
	output logic             sel_o,    // Mailbox select.
	output logic             rnw_o,    // Host 1 read, 0 write.
	output logic      [31:0] wdata_o,  // Host write data.
	output logic      [3:0]  ev_o      // Event lines, bit 0 is line a.
);
	initial begin
		sel_o = 1'h0;
		rnw_o = 1'h1;
		wdata_o = 32'h0;
		ev_o = 4'h0;
	end
	// Callers write only while inbound is empty and read only while outbound is ready.
	task automatic host_xfer(input logic rd, input logic [31:0] d);
		@(posedge clk_i);
		sel_o <= 1'h1;
		rnw_o <= rd;
		wdata_o <= d;
		@(posedge clk_i);
		sel_o <= 1'h0;
		// Released data is inverted so a stale word cannot pass for a fresh one.
		wdata_o <= ~d;
		repeat (2) @(posedge clk_i);
	endtask : host_xfer
	task automatic set_ev(input logic [3:0] v);
		@(posedge clk_i);
		ev_o <= v;
		repeat (4) @(posedge clk_i);
	endtask : set_ev
endmodule : hmbx_host_model
`default_nettype wire

/* dv/hmbx_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin $display("ERROR %s exp %0h got %0h", n, e, g); num_errors++; end end
module hmbx_top_tb;
	import hmbx_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, ack, irq, full, rdy, msel, mrnw, m_full, m_rdy;
	logic [7:0]  adr;
	logic [31:0] dat, rdat, hwd, hrd, rd, d;
	logic [3:0]  sel, evi, evo, m_evo, m_evi, v, bsel;
	logic [31:0] m_out;
	logic [5:0]  m_irq, m_mask;
	int          num_errors, compares;

	initial begin
		clk_i = 1'h0;
		forever #50 clk_i = ~clk_i;
	end

	hmbx_top uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.irq_o(irq), .mailbox_select_i(msel), .host_read_not_write_i(mrnw),
		.host_wdata_i(hwd), .host_rdata_o(hrd), .inbound_full_o(full), .outbound_ready_o(rdy),
		.chip_event_in_a_i(evi[0]), .chip_event_in_b_i(evi[1]), .chip_event_in_c_i(evi[2]),
		.chip_event_in_d_i(evi[3]), .chip_state_out_a_o(evo[0]), .chip_state_out_b_o(evo[1]),
		.chip_state_out_c_o(evo[2]), .chip_state_out_d_o(evo[3]));

	hmbx_host_model u_host (.clk_i(clk_i), .sel_o(msel), .rnw_o(mrnw), .wdata_o(hwd), .ev_o(evi));

	task automatic summarize;
		$display("checks %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	// Entered just after a rising edge; returns one edge after release.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] x);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= x;
		sel <= bsel;
		// Only the watchdog ends this wait, so a lost acknowledge fails the run.
		do begin
			@(posedge clk_i);
		end while (ack !== 1'h1);
		rd = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clk_i);
	endtask : wb

	task automatic chk_pins;
		repeat (2) @(posedge clk_i);
		`CHK("inbound_full", m_full, full)
		`CHK("outbound_ready", m_rdy, rdy)
		`CHK("state_out", m_evo, evo)
		`CHK("irq", |(m_irq & m_mask), irq)
		wb(1'h0, OFS_STATUS, 32'h0);
		`CHK("status", {30'h0, m_rdy, m_full}, rd)
		wb(1'h0, OFS_IRQ_STAT, 32'h0);
		`CHK("irq_stat", m_irq, rd[5:0])
		wb(1'h0, OFS_EVENT, 32'h0);
		`CHK("event", {m_evo, m_evi}, rd[7:0])
	endtask : chk_pins

	initial begin
		rst_i = 1'h1;
		{cyc, stb, we, adr, dat, sel} = '0;
		{m_full, m_rdy, m_evo, m_evi, m_irq, m_mask} = '0;
		bsel = 4'hF;
		m_out = '0;
		num_errors = 0;
		compares = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'h0;
		void'($urandom(69717));
		@(posedge clk_i);
		`CHK("state_out_init", EVT_OUT_RST, evo)
		chk_pins();
		$display("test reset done");
		m_mask = 6'h3F;
		wb(1'h1, OFS_IRQ_MASK, 32'h3F);
		repeat (3) begin
			d = $urandom;
			u_host.host_xfer(1'h0, d);
			m_full = 1'h1;
			m_irq[0] = 1'h1;
			chk_pins();
			wb(1'h0, OFS_INBOUND, 32'h0);
			`CHK("inbound_data", d, rd)
			m_full = 1'h0;
			chk_pins();
			d = $urandom;
			// Random byte lanes exercise the partial write of the outbound word.
			bsel = 4'($urandom);
			wb(1'h1, OFS_OUTBOUND, d);
			for (int b = 0; b < 4; b++) begin
				if (bsel[b]) begin
					m_out[b*8 +: 8] = d[b*8 +: 8];
				end
			end
			bsel = 4'hF;
			m_rdy = 1'h1;
			chk_pins();
			u_host.host_xfer(1'h1, $urandom);
			`CHK("host_rdata", m_out, hrd)
			m_rdy = 1'h0;
			m_irq[1] = 1'h1;
			chk_pins();
		end
		wb(1'h1, OFS_IRQ_STAT, 32'h3);
		m_irq = 6'h0;
		chk_pins();
		$display("test mailbox done");
		m_mask = 6'h0;
		wb(1'h1, OFS_IRQ_MASK, 32'h0);
		for (int i = 0; i < 4; i++) begin
			m_evi[i] = 1'h1;
			m_irq[2 + i] = 1'h1;
			u_host.set_ev(m_evi);
			chk_pins();
		end
		u_host.set_ev(4'h0);
		m_evi = 4'h0;
		v = 4'($urandom);
		u_host.set_ev(v);
		m_irq = m_irq | {v, 2'h0};
		m_evi = v;
		chk_pins();
		m_mask = 6'h3F;
		wb(1'h1, OFS_IRQ_MASK, 32'h3F);
		chk_pins();
		wb(1'h1, OFS_IRQ_STAT, 32'h3F);
		m_irq = 6'h0;
		chk_pins();
		$display("test events done");
		repeat (3) begin
			v = 4'($urandom);
			wb(1'h1, OFS_EVENT, {24'h0, v, 4'hF});
			m_evo = v;
			chk_pins();
			d = $urandom;
			wb(1'h1, OFS_EVENT_SET, d);
			m_evo = m_evo | d[3:0];
			d = $urandom;
			wb(1'h1, OFS_EVENT_CLR, d);
			m_evo = m_evo & ~d[3:0];
			wb(1'h1, OFS_STATUS, 32'hFFFFFFFF);
			chk_pins();
		end
		$display("test outputs done");
		wb(1'h1, 8'h20, $urandom);
		wb(1'h0, 8'h20, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		chk_pins();
		$display("test unmapped done");
		summarize();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		summarize();
	end
endmodule : hmbx_top_tb
`default_nettype wire
